// >>> seb_top.sv
// Servo enable, power stage, holding brake and dynamic brake sequencer
`include "seb_cfg.svh"

// Functional notes
// (RL1) Ready rises about 1.5 s after main power; enable is ignored before.
// (RL2) With ready and enable active the power stage is switched on.
// (RL3) Enable loss or an alarm switches the power stage off, motor free.
// (RL4) Speed below the standstill threshold (0..1000, default 5) is still.
// (RL5) Still disable drops the brake at once, power off after 0..2000 ms.
// (RL6) Brake releases after the open delay (0..1000 ms) from power on.
// (RL7) Running disable cuts power, brake holds off until wait or speed.
// (RL8) Running brake speed ranges 0..3000 r/min, default 100.
// (RL9) Output 1 carries the dynamic brake when its code is 30 (def 2).
// (RL10) While energized the dynamic brake relay is held open.
// (RL11) With the output assigned, disable applies the dynamic brake.
// (RL12) Mode 0 with control power and output 1 not assigned lets the motor coast and stay free.
// (RL13) Mode 1 with control power brakes and keeps the brake applied.
// (RL14) Control power loss applies the dynamic brake whatever the setup.
// (RL15) Powered off, the dynamic brake is always effective.
// (RL16) The controller should not start and stop the motor via enable.
// (RL17) Delays count millisecond ticks and restart on each transition.
module seb_top #(
   parameter int TICK_CYCLES = `SEB_TICK_CYC,
   parameter int SPD_W       = 16
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [7:0]       i_paddr,
   input  wire logic [31:0]      i_pwdata,
   output logic      [31:0]      o_prdata,
   output logic                  o_pready,
   output logic                  o_pslverr,
   input  wire logic             i_main_power,
   input  wire logic             i_ctrl_power,
   input  wire logic             i_servo_enable_in,
   input  wire logic             i_alarm,
   input  wire logic [SPD_W-1:0] i_motor_speed,
   output logic                  o_ready,
   output logic                  o_power_on,
   output logic                  o_brake_release_out,
   output logic                  o_dynamic_brake_out,
   output logic                  o_digital_output_1
);
   seb_pkg::seb_state_e state;
   seb_pkg::seb_state_e next_state;
   logic        dyn_braking_mode;
   logic [7:0]  output1_function_code;
   logic [15:0] standstill_speed_threshold;
   logic [15:0] stationary_brake_delay;
   logic [15:0] running_brake_wait_time;
   logic [15:0] running_brake_speed;
   logic [15:0] brake_open_delay;
   logic        next_mode;
   logic [7:0]  next_fc;
   logic [15:0] next_still, next_stat, next_wait, next_rspd, next_open;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   logic        next_ready, next_power_on, next_brake, next_db, next_do1;

   logic        tick, pup_done, ph_done;
   logic [15:0] ph_limit;
   logic        powered, stationary, slow_enough;
   logic        db_assigned, db_apply, wr_en, rd_en;
   // Millisecond timebase
   seb_ms_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_tick     (tick)
   );

   // (RL1) power-up wait
   seb_delay_cnt #(
      .W (16)
   ) u_pup (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_restart  (!powered),
      .i_tick     (tick),
      .i_limit    (`SEB_PWRUP_MS),
      .o_done     (pup_done)
   );

   // (RL17) phase timer restart
   seb_delay_cnt #(
      .W (16)
   ) u_phase (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_restart  (next_state != state),
      .i_tick     (tick),
      .i_limit    (ph_limit),
      .o_done     (ph_done)
   );

   // Supply and speed qualifiers
   assign powered     = i_main_power && i_ctrl_power;
   // (RL4) standstill compare
   assign stationary  = (32'(i_motor_speed) < 32'(standstill_speed_threshold));
   // (RL8) running brake speed
   assign slow_enough = (32'(i_motor_speed) <= 32'(running_brake_speed));
   // (RL9) output function select
   assign db_assigned = (output1_function_code == `SEB_FC_DYN_BRAKE);
   // (RL11) assigned output or mode 1 brakes
   assign db_apply    = db_assigned || dyn_braking_mode;

   // Delay used by the current phase
   always_comb begin
      case (state)
         seb_pkg::ST_OPENING:   ph_limit = brake_open_delay;
         seb_pkg::ST_STOP_HOLD: ph_limit = stationary_brake_delay;
         seb_pkg::ST_COAST:     ph_limit = running_brake_wait_time;
         default:               ph_limit = 16'h0000;
      endcase
   end

   // Sequencer next state and output levels
   always_comb begin
      next_state = state;
      case (state)
         seb_pkg::ST_POWERUP: begin
            // (RL1) ready after the wait
            if (pup_done) begin
               next_state = seb_pkg::ST_IDLE;
            end
         end
         seb_pkg::ST_IDLE: begin
            // (RL2) enable starts the power stage
            if (i_servo_enable_in && !i_alarm) begin
               next_state = seb_pkg::ST_OPENING;
            end
         end
         seb_pkg::ST_OPENING, seb_pkg::ST_RUN: begin
            // (RL6) release after open delay
            if (state == seb_pkg::ST_OPENING && ph_done) begin
               next_state = seb_pkg::ST_RUN;
            end
            // (RL5) still disable holds power
            if (!i_servo_enable_in) begin
               next_state = (stationary || state == seb_pkg::ST_OPENING)
                            ? seb_pkg::ST_STOP_HOLD : seb_pkg::ST_COAST;
            end
         end
         seb_pkg::ST_STOP_HOLD: begin
            if (ph_done) begin
               next_state = seb_pkg::ST_IDLE;
            end
         end
         seb_pkg::ST_COAST: begin
            // (RL7) first of wait or speed
            if (ph_done || slow_enough) begin
               next_state = seb_pkg::ST_IDLE;
            end
         end
         default: next_state = seb_pkg::ST_POWERUP;
      endcase
      // (RL3) alarm frees the motor
      if (i_alarm && state != seb_pkg::ST_POWERUP) begin
         next_state = seb_pkg::ST_IDLE;
      end
      // (RL14) supply loss ends operation
      if (!powered) begin
         next_state = seb_pkg::ST_POWERUP;
      end
      next_ready    = (next_state != seb_pkg::ST_POWERUP);
      next_power_on = (next_state == seb_pkg::ST_OPENING) ||
                      (next_state == seb_pkg::ST_RUN) ||
                      (next_state == seb_pkg::ST_STOP_HOLD);
      next_brake    = (next_state == seb_pkg::ST_RUN) ||
                      (next_state == seb_pkg::ST_COAST);
      // (RL10) (RL12) (RL13) (RL15) relay open only when safe
      next_db       = powered && (next_power_on || !db_apply);
      next_do1      = db_assigned && next_db;
   end

   // Sequencer registers
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state               <= seb_pkg::ST_POWERUP;
         o_ready             <= 1'b0;
         o_power_on          <= 1'b0;
         o_brake_release_out <= 1'b0;
         o_dynamic_brake_out <= 1'b0;
         o_digital_output_1  <= 1'b0;
      end else begin
         state               <= next_state;
         o_ready             <= next_ready;
         o_power_on          <= next_power_on;
         o_brake_release_out <= next_brake;
         o_dynamic_brake_out <= next_db;
         o_digital_output_1  <= next_do1;
      end
   end

   // APB: one wait state, write at the edge that sees pready
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
   assign rd_en = i_psel && i_penable && !o_pready && !i_pwrite;
   // Register file next values and read mux
   always_comb begin
      next_mode    = dyn_braking_mode;
      next_fc      = output1_function_code;
      next_still   = standstill_speed_threshold;
      next_stat    = stationary_brake_delay;
      next_wait    = running_brake_wait_time;
      next_rspd    = running_brake_speed;
      next_open    = brake_open_delay;
      next_prdata  = o_prdata;
      next_pready  = i_psel && i_penable && !o_pready;
      next_pslverr = 1'b0;
      if (i_paddr == `SEB_OFS_CTRL) begin
         if (wr_en) begin
            next_mode = i_pwdata[`SEB_CTRL_MODE_BIT];
            next_fc   = i_pwdata[`SEB_CTRL_FC_MSB:`SEB_CTRL_FC_LSB];
         end
         next_prdata = {16'h0000, output1_function_code, 7'h00,
                        dyn_braking_mode};
      end else if (i_paddr == `SEB_OFS_STILL_SPD) begin
         if (wr_en) next_still = i_pwdata[15:0];
         next_prdata = {16'h0000, standstill_speed_threshold};
      end else if (i_paddr == `SEB_OFS_STAT_DLY) begin
         if (wr_en) next_stat = i_pwdata[15:0];
         next_prdata = {16'h0000, stationary_brake_delay};
      end else if (i_paddr == `SEB_OFS_RUN_WAIT) begin
         if (wr_en) next_wait = i_pwdata[15:0];
         next_prdata = {16'h0000, running_brake_wait_time};
      end else if (i_paddr == `SEB_OFS_RUN_SPD) begin
         if (wr_en) next_rspd = i_pwdata[15:0];
         next_prdata = {16'h0000, running_brake_speed};
      end else if (i_paddr == `SEB_OFS_OPEN_DLY) begin
         if (wr_en) next_open = i_pwdata[15:0];
         next_prdata = {16'h0000, brake_open_delay};
      end else if (i_paddr == `SEB_OFS_STATUS) begin
         next_prdata = {24'h00_0000, 1'b0, stationary, 1'b0,
                        o_digital_output_1, o_dynamic_brake_out,
                        o_brake_release_out, o_power_on, o_ready};
      end else begin
         next_prdata  = 32'h0000_0000;
         next_pslverr = next_pready;
      end
      if (!rd_en) next_prdata = (o_pready) ? 32'h0000_0000 : o_prdata;
   end
   // Register file
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         dyn_braking_mode           <= `SEB_RST_MODE;
         output1_function_code      <= `SEB_RST_FC;
         standstill_speed_threshold <= `SEB_RST_STILL_SPD;
         stationary_brake_delay     <= `SEB_RST_STAT_DLY;
         running_brake_wait_time    <= `SEB_RST_RUN_WAIT;
         running_brake_speed        <= `SEB_RST_RUN_SPD;
         brake_open_delay           <= `SEB_RST_OPEN_DLY;
         o_prdata                   <= 32'h0000_0000;
         o_pready                   <= 1'b0;
         o_pslverr                  <= 1'b0;
      end else begin
         dyn_braking_mode           <= next_mode;
         output1_function_code      <= next_fc;
         standstill_speed_threshold <= next_still;
         stationary_brake_delay     <= next_stat;
         running_brake_wait_time    <= next_wait;
         running_brake_speed        <= next_rspd;
         brake_open_delay           <= next_open;
         o_prdata                   <= next_prdata;
         o_pready                   <= next_pready;
         o_pslverr                  <= next_pslverr;
      end
   end
   // Checks on the sequencer
   property p_ready_after_wait;
      @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_ready) |-> $past(pup_done) && $past(powered);
   endproperty
   a_ready_after_wait: assert property (p_ready_after_wait) // (RL1)
      else $error("ready rose before the power-up wait");

   property p_run_energized;
      @(posedge i_core_clk) disable iff (i_rst)
      (state == seb_pkg::ST_IDLE && i_servo_enable_in && !i_alarm
       && powered) |=> o_power_on ##1 o_power_on || !i_servo_enable_in
       || i_alarm || !powered;
   endproperty
   a_run_energized: assert property (p_run_energized) // (RL2)
      else $error("enable did not energize the motor");

   property p_alarm_free;
      @(posedge i_core_clk) disable iff (i_rst)
      i_alarm |=> !o_power_on && !o_brake_release_out;
   endproperty
   a_alarm_free: assert property (p_alarm_free) // (RL3)
      else $error("power stage stayed on under alarm");

   property p_still_stop;
      @(posedge i_core_clk) disable iff (i_rst)
      (state == seb_pkg::ST_RUN && !i_servo_enable_in && stationary
       && !i_alarm && powered) |=> o_power_on && !o_brake_release_out;
   endproperty
   a_still_stop: assert property (p_still_stop) // (RL5)
      else $error("still disable mishandled power or brake");

   property p_open_needs_power;
      @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_brake_release_out) |-> $past(o_power_on, 1) && o_power_on;
   endproperty
   a_open_needs_power: assert property (p_open_needs_power) // (RL6)
      else $error("brake released without motor current");

   property p_run_stop;
      @(posedge i_core_clk) disable iff (i_rst)
      (state == seb_pkg::ST_RUN && !i_servo_enable_in && !stationary
       && !slow_enough && !i_alarm && powered)
      |=> !o_power_on && o_brake_release_out;
   endproperty
   a_run_stop: assert property (p_run_stop) // (RL7)
      else $error("running disable mishandled power or brake");

   property p_db_open_energized;
      @(posedge i_core_clk) disable iff (i_rst)
      o_power_on |-> o_dynamic_brake_out;
   endproperty
   a_db_open_energized: assert property (p_db_open_energized) // (RL10)
      else $error("dynamic brake applied while energized");

   property p_ctrl_loss_db;
      @(posedge i_core_clk) disable iff (i_rst)
      !i_ctrl_power |=> !o_dynamic_brake_out && !o_power_on && !o_ready;
   endproperty
   a_ctrl_loss_db: assert property (p_ctrl_loss_db) // (RL14)
      else $error("dynamic brake not applied on control power loss");
   // Main scenarios
   c_run: cover property (@(posedge i_core_clk) disable iff (i_rst)
      state == seb_pkg::ST_RUN);
   c_hold: cover property (@(posedge i_core_clk) disable iff (i_rst)
      state == seb_pkg::ST_STOP_HOLD ##1 state == seb_pkg::ST_IDLE);
   c_coast: cover property (@(posedge i_core_clk) disable iff (i_rst)
      state == seb_pkg::ST_COAST ##1 state == seb_pkg::ST_IDLE);
endmodule : seb_top

// >>> seb_cfg.svh
// Offsets, reset values and timing counts of the enable and brake sequencer
`ifndef SEB_CFG_SVH
`define SEB_CFG_SVH

// Register byte offsets
`define SEB_OFS_CTRL      8'h00
`define SEB_OFS_STILL_SPD 8'h04
`define SEB_OFS_STAT_DLY  8'h08
`define SEB_OFS_RUN_WAIT  8'h0C
`define SEB_OFS_RUN_SPD   8'h10
`define SEB_OFS_OPEN_DLY  8'h14
`define SEB_OFS_STATUS    8'h18

// Control register field positions
`define SEB_CTRL_MODE_BIT 0
`define SEB_CTRL_FC_LSB   8
`define SEB_CTRL_FC_MSB   15

// Reset values of the settings
`define SEB_RST_MODE      1'b0
`define SEB_RST_FC        8'h02
`define SEB_RST_STILL_SPD 16'h0005
`define SEB_RST_STAT_DLY  16'h0096
`define SEB_RST_RUN_WAIT  16'h0000
`define SEB_RST_RUN_SPD   16'h0064
`define SEB_RST_OPEN_DLY  16'h0000

// Output function code that selects the dynamic brake
`define SEB_FC_DYN_BRAKE  8'h1E

// Timing
`define SEB_CLK_PERIOD_NS 20
`define SEB_TICK_NS       1000000
`define SEB_TICK_CYC      (`SEB_TICK_NS / `SEB_CLK_PERIOD_NS)
`define SEB_PWRUP_MS      16'h05DC

`endif

// >>> seb_pkg.sv
// Types shared by the enable and brake sequencer
package seb_pkg;
   typedef enum logic [2:0] {
      ST_POWERUP,
      ST_IDLE,
      ST_OPENING,
      ST_RUN,
      ST_STOP_HOLD,
      ST_COAST
   } seb_state_e;
endpackage : seb_pkg

// >>> seb_ms_tick.sv
// Divider that makes a one-cycle pulse once per millisecond
module seb_ms_tick #(
   parameter int TICK_CYCLES = 50000
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   output logic      o_tick
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        next_tick;

   // Count up the cycles of one millisecond
   always_comb begin
      next_tick = 1'b0;
      next_cnt  = cnt + 32'h0000_0001;
      if (cnt >= 32'(TICK_CYCLES - 1)) begin
         next_cnt  = 32'h0000_0000;
         next_tick = 1'b1;
      end
   end

   // Register the divider
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt    <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         o_tick <= next_tick;
      end
   end

   // Tick is a single-cycle pulse
   property p_tick_single;
      @(posedge i_core_clk) disable iff (i_rst)
      o_tick |=> !o_tick;
   endproperty
   a_tick_single: assert property (p_tick_single) // (RL17)
      else $error("timebase tick longer than one cycle");
endmodule : seb_ms_tick

// >>> seb_delay_cnt.sv
// Millisecond delay counter with restart and a limit compare
module seb_delay_cnt #(
   parameter int W = 16
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_restart,
   input  wire logic         i_tick,
   input  wire logic [W-1:0] i_limit,
   output logic              o_done
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   // Restart clears, each tick counts up, saturating at the top
   always_comb begin
      next_cnt = cnt;
      if (i_restart) begin
         next_cnt = '0;
      end else if (i_tick && (cnt != {W{1'b1}})) begin
         next_cnt = cnt + W'(1);
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign o_done = (cnt >= i_limit);
endmodule : seb_delay_cnt

// >>> seb_motor_model.sv
// Behavioural motor behind the sequencer: speed follows drive and brakes
module seb_motor_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_power_on,
   input  wire logic        i_brake_release_out,
   input  wire logic        i_dynamic_brake_out,
   input  wire logic [15:0] i_target,
   output logic      [15:0] o_speed
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] step;

   // Shorted windings stop the rotor faster than free coasting
   assign step = i_dynamic_brake_out ? 16'h0004 : 16'h0010;

   // Energized: speed jumps to target; engaged brake holds it at zero
   always_ff @(posedge i_core_clk) begin
      if (i_power_on)
         o_speed <= i_target;
      else if (!i_brake_release_out || o_speed <= step)
         o_speed <= 16'h0000;
      else
         o_speed <= o_speed - step;
   end
endmodule : seb_motor_model

// >>> test_servo_enable_brake_sequencer.sv
// Self-checking bench of the enable and brake sequencer
module test_servo_enable_brake_sequencer;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic        pready, pslverr, err, main_pw, ctrl_pw, servo_enable_in, alarm;
   logic [15:0] speed, target;
   logic        ready, pon, brake_release_out, db, do1, md;
   logic [7:0]  fc;
   int          n_fail, n_compared, n, cyc;

   seb_top #(.TICK_CYCLES(10)) dut_u (
      .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_main_power(main_pw), .i_ctrl_power(ctrl_pw),
      .i_servo_enable_in(servo_enable_in), .i_alarm(alarm), .i_motor_speed(speed),
      .o_ready(ready), .o_power_on(pon), .o_brake_release_out(brake_release_out),
      .o_dynamic_brake_out(db), .o_digital_output_1(do1));

   seb_motor_model motor_u (
      .i_core_clk(clk), .i_power_on(pon), .i_brake_release_out(brake_release_out),
      .i_dynamic_brake_out(db), .i_target(target), .o_speed(speed));

   // Clock and cycle count since reset release
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

   task automatic wrap_up;
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   function automatic logic outs(input int i);
      logic [3:0] s;
      s = {ready, db, brake_release_out, pon};
      return s[i];
   endfunction : outs

   // Bounded wait for output i (0 power, 1 brake, 2 db, 3 ready)
   task automatic wait_on(input int i, input logic val, input int lim);
      n = 0;
      while (outs(i) !== val) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            n_fail++;
            wrap_up();
         end
      end
   endtask : wait_on

   function automatic logic [31:0] rst_val(input int i);
      case (i)
         0: return 32'h0000_0200;
         1: return 32'h0000_0005;
         2: return 32'h0000_0096;
         4: return 32'h0000_0064;
         6: return 32'h0000_0048;
         default: return 32'h0000_0000;
      endcase
   endfunction : rst_val

   // Dynamic brake level once stopped with power present
   function automatic logic db_exp(input logic m, input logic [7:0] c);
      return !(m || c == 8'h1E);
   endfunction : db_exp

   initial begin
      {rst, main_pw, ctrl_pw} = 3'h7;
      {psel, penable, pwrite, servo_enable_in, alarm} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      target = 16'h0000;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(32'h8532));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({ready, pon, brake_release_out}, 0);
      // Reset values, then an unmapped slot
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(i * 4), 0);
         chk(rd, rst_val(i));
      end
      apb(1'b0, 8'h1C, 0);
      chk(rd | {err, 31'h0}, 32'h8000_0000);
      v = $urandom_range(1000);
      apb(1'b1, 8'h04, v);
      apb(1'b0, 8'h04, 0);
      chk(rd, v);
      v = $urandom_range(3000);
      apb(1'b1, 8'h10, v);
      apb(1'b0, 8'h10, 0);
      chk(rd, v);
      apb(1'b1, 8'h04, 5);
      apb(1'b1, 8'h10, 100);
      apb(1'b1, 8'h14, 2);
      apb(1'b1, 8'h08, 3);
      apb(1'b1, 8'h0C, 50);
      // Enable before ready must be ignored
      servo_enable_in <= 1'b1;
      repeat (13000) @(posedge clk);
      chk({ready, pon}, 0);
      servo_enable_in <= 1'b0;
      wait_on(3, 1'b1, 2500);
      chk(cyc >= 14990, 1);
      // per setup, enable dropped once while running, then re-enabled and dropped again once stopped
      for (int i = 0; i < 3; i++) begin
         md = (i == 1);
         fc = (i == 2) ? 8'h1E : 8'h02;
         apb(1'b1, 8'h00, {16'h0, fc, 7'h0, md});
         target <= 16'(500 + $urandom_range(500));
         servo_enable_in <= 1'b1;
         wait_on(0, 1'b1, 4);
         chk(brake_release_out, 0);
         wait_on(1, 1'b1, 40);
         chk(n >= 9, 1);
         chk(db, 1);
         chk(do1, (i == 2));
         servo_enable_in <= 1'b0;
         wait_on(0, 1'b0, 4);
         chk(brake_release_out, 1);
         wait_on(1, 1'b0, 400);
         chk(speed <= 100, 1);
         chk(db, db_exp(md, fc));
         chk(do1, (i == 2) ? db_exp(md, fc) : 1'b0);
         target <= 16'h0000;
         servo_enable_in <= 1'b1;
         wait_on(1, 1'b1, 40);
         servo_enable_in <= 1'b0;
         wait_on(1, 1'b0, 4);
         chk(pon, 1);
         wait_on(0, 1'b0, 40);
         chk(n >= 18, 1);
      end
      // Alarm while energized
      target <= 16'h0258;
      servo_enable_in <= 1'b1;
      wait_on(0, 1'b1, 4);
      alarm <= 1'b1;
      wait_on(0, 1'b0, 4);
      chk(brake_release_out, 0);
      alarm <= 1'b0;
      servo_enable_in <= 1'b0;
      repeat (5) @(posedge clk);
      // Control power lost while running
      servo_enable_in <= 1'b1;
      wait_on(1, 1'b1, 40);
      ctrl_pw <= 1'b0;
      wait_on(2, 1'b0, 4);
      chk({ready, pon}, 0);
      main_pw <= 1'b0;
      servo_enable_in <= 1'b0;
      repeat (20) @(posedge clk);
      chk(db, 0);
      wrap_up();
   end
endmodule : test_servo_enable_brake_sequencer
